// file: design/icp_cfg.svh
// Constants for the instruction cycle pipeline: widths, reset values, timing.
// Assumes inclusion by the pipeline package and modules only.
`ifndef ICP_CFG_SVH
`define ICP_CFG_SVH
`define ICP_PC_WIDTH      13
`define ICP_INSTR_WIDTH   14
`define ICP_DATA_WIDTH    8
`define ICP_DADDR_WIDTH   9
`define ICP_RESET_VECTOR  13'h0000
`define ICP_NOP_WORD      14'h0000
`define ICP_PHASE_COUNT   4
`define ICP_CLOCK_OUT_PIN_RESET  1'b0
`endif

// file: design/icp_pkg.sv
// Types shared by the instruction cycle pipeline modules.
// Assumes icp_cfg.svh is on the include path.
`include "icp_cfg.svh"
package icp_pkg;
   typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} icp_phase_e;
   typedef logic [`ICP_PC_WIDTH-1:0] icp_pc_t;
   typedef logic [`ICP_INSTR_WIDTH-1:0] icp_instr_t;
endpackage : icp_pkg

// file: design/icp_phase_gen.sv
// Quadrature phase generator: one strobe per oscillator period, four per cycle.
// Assumes the core clock is the oscillator input and reset is asynchronous.
`timescale 1ns/1ps
module icp_phase_gen (
   input  wire logic sys_clk_in,              // Oscillator input clock
   input  wire logic arst_n_in,               // Async reset, active low
   output icp_pkg::icp_phase_e phase_out,     // Current phase
   output logic      cycle_last_out           // High in phase_four
);
   icp_pkg::icp_phase_e phase_q;
   icp_pkg::icp_phase_e phase_d;

   // Next phase strictly one, two, three, four
   always_comb
   begin
      unique case (phase_q)
         icp_pkg::PH_ONE:   phase_d = icp_pkg::PH_TWO;
         icp_pkg::PH_TWO:   phase_d = icp_pkg::PH_THREE;
         icp_pkg::PH_THREE: phase_d = icp_pkg::PH_FOUR;
         icp_pkg::PH_FOUR:  phase_d = icp_pkg::PH_ONE;
      endcase
   end

   // Restart at phase_one on reset
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         phase_q <= icp_pkg::PH_ONE;
      else
         phase_q <= phase_d;
   end

   assign phase_out      = phase_q;
   assign cycle_last_out = (phase_q == icp_pkg::PH_FOUR);
endmodule : icp_phase_gen

// file: design/icp_pipeline.sv
// Instruction cycle pipeline: phase strobes, fetch/execute overlap, branch flush.
// Assumes synchronous program/data memories and an external decode datapath that
// reports branches and targets during the execute cycle.
`timescale 1ns/1ps
`include "icp_cfg.svh"
module icp_pipeline #(
   parameter int PC_WIDTH    = `ICP_PC_WIDTH,
   parameter int INSTR_WIDTH = `ICP_INSTR_WIDTH
) (
   input  wire logic                   sys_clk_in,          // Oscillator input clock
   input  wire logic                   arst_n_in,           // Async reset, active low
   input  wire logic                   rc_mode_in,          // RC oscillator mode select
   input  wire logic [INSTR_WIDTH-1:0] prog_data_in,        // Program memory read word
   input  wire logic                   branch_in,           // Executing word changes PC
   input  wire logic [PC_WIDTH-1:0]    branch_target_in,    // New PC for a branch
   output logic      [PC_WIDTH-1:0]    prog_addr_out,       // Program memory address
   output logic      [INSTR_WIDTH-1:0] instr_out,           // Instruction register
   output logic                        exec_valid_out,      // Instruction register holds real work
   output logic                        phase_one_out,       // Phase strobe one
   output logic                        phase_two_out,       // Phase strobe two
   output logic                        phase_three_out,     // Phase strobe three
   output logic                        phase_four_out,      // Phase strobe four
   output logic                        dmem_rd_out,         // Operand read strobe
   output logic                        dmem_wr_out,         // Destination write strobe
   output logic                        clock_out_pin_out,   // Instruction rate clock
   output logic                        clock_out_oe_out     // Clock out drive enable
);
   icp_pkg::icp_phase_e    phase_s;
   icp_pkg::icp_phase_e    phase_nx;
   logic                   last_s;
   logic [PC_WIDTH-1:0]    pc_q;       // Fetch address
   logic [PC_WIDTH-1:0]    pc_d;
   logic [INSTR_WIDTH-1:0] ir_q;       // Word in the execute slot
   logic [INSTR_WIDTH-1:0] ir_d;
   logic                   fvalid_q;   // Advance the address at the next phase_one
   logic                   fvalid_d;
   logic                   xvalid_q;   // Execute slot holds real work
   logic                   xvalid_d;
   logic                   flush_q;    // Branch taken, drop the word in flight
   logic                   flush_d;
   logic [3:0]             strobe_q;   // One-hot phase strobes
   logic [3:0]             strobe_d;
   logic                   rd_q;       // Operand read strobe
   logic                   rd_d;
   logic                   wr_q;       // Destination write strobe
   logic                   wr_d;
   logic                   ck_q;       // Instruction rate clock
   logic                   ck_d;
   logic                   oe_q;       // Clock out drive enable
   logic                   oe_d;

   // Shared phase counter
   icp_phase_gen u_phase (
      .sys_clk_in     (sys_clk_in),
      .arst_n_in      (arst_n_in),
      .phase_out      (phase_s),
      .cycle_last_out (last_s)
   );

   // Strobes are registered, so they are decoded from the next phase and line up with the counter
   always_comb
   begin
      unique case (phase_s)
         icp_pkg::PH_ONE:   phase_nx = icp_pkg::PH_TWO;
         icp_pkg::PH_TWO:   phase_nx = icp_pkg::PH_THREE;
         icp_pkg::PH_THREE: phase_nx = icp_pkg::PH_FOUR;
         icp_pkg::PH_FOUR:  phase_nx = icp_pkg::PH_ONE;
      endcase
   end

   // Pipeline next state
   always_comb
   begin
      pc_d     = pc_q;
      ir_d     = ir_q;
      fvalid_d = fvalid_q;
      xvalid_d = xvalid_q;
      flush_d  = flush_q;
      // Fetch: advance address at phase_one
      if (phase_s == icp_pkg::PH_ONE && fvalid_q)
         pc_d = pc_q + {{(PC_WIDTH-1){1'b0}}, 1'b1};
      // Branch seen during execute loads the target for the next fetch;
      // the word read in this cycle's phase_four is thrown away and the
      // target is read again in the following cycle
      if (phase_s == icp_pkg::PH_THREE && xvalid_q && branch_in)
      begin
         pc_d    = branch_target_in;
         flush_d = 1'b1;
      end
      // Fetched word goes straight into the instruction register at phase_four,
      // so it executes in the very next cycle; a second holding stage would
      // add a cycle of latency to every instruction
      if (last_s)
      begin
         // The word fetched behind a branch is replaced by a no-op
         ir_d     = flush_q ? INSTR_WIDTH'(`ICP_NOP_WORD) : prog_data_in;
         xvalid_d = !flush_q;
         // No advance after reset or a flush, so the vector or target is fetched
         fvalid_d = !flush_q;
         flush_d  = 1'b0;
      end
   end

   // Pipeline registers; first cycle after reset only fetches
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         pc_q     <= PC_WIDTH'(`ICP_RESET_VECTOR);
         ir_q     <= INSTR_WIDTH'(`ICP_NOP_WORD);
         fvalid_q <= 1'b0;
         xvalid_q <= 1'b0;
         flush_q  <= 1'b0;
      end
      else
      begin
         pc_q     <= pc_d;
         ir_q     <= ir_d;
         fvalid_q <= fvalid_d;
         xvalid_q <= xvalid_d;
         flush_q  <= flush_d;
      end
   end

   // Output strobes decoded from the next phase so they are flop outputs
   always_comb
   begin
      strobe_d = 4'h0;
      strobe_d[phase_nx] = 1'b1;
      // Memory strobes only for real work in the execute slot
      rd_d = (phase_nx == icp_pkg::PH_TWO)  && xvalid_d;
      wr_d = (phase_nx == icp_pkg::PH_FOUR) && xvalid_d;
      // Instruction rate clock: high over phases one and two
      ck_d = rc_mode_in &&
             (phase_nx == icp_pkg::PH_ONE || phase_nx == icp_pkg::PH_TWO);
      oe_d = rc_mode_in;
   end

   // Strobe registers; reset state matches phase_one active
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         strobe_q <= 4'h1;
         rd_q     <= 1'b0;
         wr_q     <= 1'b0;
         ck_q     <= `ICP_CLOCK_OUT_PIN_RESET;
         oe_q     <= 1'b0;
      end
      else
      begin
         strobe_q <= strobe_d;
         rd_q     <= rd_d;
         wr_q     <= wr_d;
         ck_q     <= ck_d;
         oe_q     <= oe_d;
      end
   end

   // PC and IR are flops already
   assign prog_addr_out     = pc_q;
   assign instr_out         = ir_q;
   assign exec_valid_out    = xvalid_q;
   assign phase_one_out     = strobe_q[0];
   assign phase_two_out     = strobe_q[1];
   assign phase_three_out   = strobe_q[2];
   assign phase_four_out    = strobe_q[3];
   assign dmem_rd_out       = rd_q;
   assign dmem_wr_out       = wr_q;
   assign clock_out_pin_out = ck_q;
   assign clock_out_oe_out  = oe_q;
endmodule : icp_pipeline

// file: testbench/icp_pipeline_checker.sv
// Checker of phase strobes, memory strobes, branch flush and clock out.
// Assumes it is bound onto every icp_pipeline instance.
`timescale 1ns/1ps
module icp_pipeline_checker (
   input wire logic sys_clk_in,        // Clock
   input wire logic arst_n_in,         // Reset
   input wire logic rc_mode_in,        // RC mode
   input wire logic branch_in,         // Branch
   input wire logic exec_valid_out,    // Real work
   input wire logic phase_one_out,     // Phase 1
   input wire logic phase_two_out,     // Phase 2
   input wire logic phase_three_out,   // Phase 3
   input wire logic phase_four_out,    // Phase 4
   input wire logic dmem_rd_out,       // Read
   input wire logic dmem_wr_out,       // Write
   input wire logic clock_out_pin_out, // Clock out
   input wire logic clock_out_oe_out   // Drive enable
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);
   // Rest of one instruction cycle
   sequence rest_s;
      phase_two_out ##1 phase_three_out ##1 phase_four_out ##1 phase_one_out;
   endsequence
   // Branch seen in phase three of real work
   sequence jump_s;
      phase_three_out && exec_valid_out && branch_in;
   endsequence
   one_phase_a: assert property ($onehot({phase_one_out, phase_two_out, phase_three_out, phase_four_out}))
      else $error("phase strobes not one-hot");
   phase_order_a: assert property (phase_one_out |=> rest_s)
      else $error("phase order broken");
   read_strobe_a: assert property (dmem_rd_out == (phase_two_out && exec_valid_out))
      else $error("operand read strobe wrong");
   write_strobe_a: assert property (dmem_wr_out == (phase_four_out && exec_valid_out))
      else $error("destination write strobe wrong");
   valid_hold_a: assert property (!phase_four_out |=> $stable(exec_valid_out))
      else $error("valid changed inside a cycle");
   branch_flush_a: assert property (jump_s |-> ##2 !exec_valid_out [*4] ##1 exec_valid_out)
      else $error("branch flush wrong");
   oe_follow_a: assert property ($past(arst_n_in) |-> clock_out_oe_out == $past(rc_mode_in))
      else $error("clock out enable wrong");
   quarter_clk_a: assert property (rc_mode_in && clock_out_oe_out && $past(clock_out_oe_out)
      |-> clock_out_pin_out == (phase_one_out || phase_two_out)) else $error("clock out rate wrong");
endmodule : icp_pipeline_checker
bind icp_pipeline icp_pipeline_checker i_icp_pipeline_checker (.*);

// file: testbench/icp_prog_mem_model.sv
// Program memory and decode model: word at address a is {1, a}.
// Assumes the bench names one address that holds a jump.
`timescale 1ns/1ps
module icp_prog_mem_model (
   input  wire logic        phase_four_in, // Capture strobe
   input  wire logic [12:0] addr_in,       // Fetch address
   input  wire logic [13:0] instr_in,      // Executing word
   input  wire logic        valid_in,      // Real work
   input  wire logic [12:0] jump_at_in,    // Jump location
   output logic      [13:0] data_out,      // Program word
   output logic             branch_out     // Jump executing
);
   // Word valid only in capture phase, inverted otherwise so early sampling shows
   assign data_out   = phase_four_in ? {1'b1, addr_in} : ~{1'b1, addr_in};
   // Decode flags the jump for its whole execute cycle
   assign branch_out = valid_in && (instr_in === {1'b1, jump_at_in});
endmodule : icp_prog_mem_model

// file: testbench/icp_pipeline_bench.sv
// Self-checking bench for the instruction cycle pipeline.
// Assumes the memory model stands on the far side; checker comes in by bind.
`timescale 1ns/1ps
module icp_pipeline_bench;
   logic        sys_clk_in = 1'b0, arst_n_in = 1'b0, rc_mode_in = 1'b0, branch_in, exec_valid_out;
   logic        phase_one_out, phase_two_out, phase_three_out, phase_four_out;
   logic        dmem_rd_out, dmem_wr_out, clock_out_pin_out, clock_out_oe_out;
   logic [12:0] branch_target_in = 13'h0100, jmp = 13'h1fff, prog_addr_out;
   logic [13:0] prog_data_in, instr_out;
   int          error_cnt = 0, cmp_count = 0;
   // Core clock, 100 MHz
   initial forever #5 sys_clk_in = ~sys_clk_in;
   icp_pipeline i_icp_pipeline (
      .sys_clk_in        (sys_clk_in),
      .arst_n_in         (arst_n_in),
      .rc_mode_in        (rc_mode_in),
      .prog_data_in      (prog_data_in),
      .branch_in         (branch_in),
      .branch_target_in  (branch_target_in),
      .prog_addr_out     (prog_addr_out),
      .instr_out         (instr_out),
      .exec_valid_out    (exec_valid_out),
      .phase_one_out     (phase_one_out),
      .phase_two_out     (phase_two_out),
      .phase_three_out   (phase_three_out),
      .phase_four_out    (phase_four_out),
      .dmem_rd_out       (dmem_rd_out),
      .dmem_wr_out       (dmem_wr_out),
      .clock_out_pin_out (clock_out_pin_out),
      .clock_out_oe_out  (clock_out_oe_out)
   );
   icp_prog_mem_model i_icp_prog_mem_model (.phase_four_in(phase_four_out), .addr_in(prog_addr_out),
      .instr_in(instr_out), .valid_in(exec_valid_out), .jump_at_in(jmp), .data_out(prog_data_in),
      .branch_out(branch_in));
   function automatic logic [15:0] wd(input logic [12:0] a);
      return {3'b001, a};
   endfunction : wd
   task automatic chk(input logic [15:0] act, input logic [15:0] exp);
      cmp_count++;
      if (act !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, act, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask : cyc
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results
   // Bounded wait for a register word, or for phase four when given all ones
   task automatic wait_on(input logic [15:0] w);
      int i;
      for (i = 0; i < 40 && (w === 16'hffff ? phase_four_out !== 1'b1 : {2'b00, instr_out} !== w); i++)
         cyc(1);
      if (i == 40)
      begin
         error_cnt++;
         results();
      end
   endtask : wait_on
   // Reset with a chosen jump location, check the empty pipeline
   task automatic do_reset(input logic [12:0] j);
      @(posedge sys_clk_in);
      arst_n_in <= 1'b0;
      jmp       <= j;
      cyc(3);
      chk(16'({phase_one_out, phase_two_out, phase_three_out, phase_four_out, exec_valid_out}), 16'h0010);
      chk(16'(instr_out), 16'h0000);
      chk(16'(prog_addr_out), 16'h0000);
      @(posedge sys_clk_in);
      arst_n_in <= 1'b1;
      cyc(2);
      chk(16'({phase_one_out, phase_two_out, phase_three_out, phase_four_out}), 16'h0004);
   endtask : do_reset
   // Straight run: each word executes one cycle after its fetch
   task automatic t_fetch;
      do_reset(13'h1fff);
      for (int k = 0; k < 6; k++)
      begin
         wait_on(16'hffff);
         cyc(1);
         chk(16'(instr_out), wd(13'(k)));
         chk(16'(exec_valid_out), 16'h0001);
         cyc(1);
         chk(16'({dmem_rd_out, dmem_wr_out}), 16'h0002);
         chk(16'(prog_addr_out), 16'(k + 1));
         cyc(2);
         chk(16'({dmem_rd_out, dmem_wr_out}), 16'h0001);
      end
   endtask : t_fetch
   // Jump at address 2: one empty cycle, then target and its successor
   task automatic t_branch;
      do_reset(13'h0002);
      wait_on(wd(13'h0002));
      cyc(4);
      chk(16'({exec_valid_out, instr_out}), 16'h0000);
      cyc(1);
      chk(16'(prog_addr_out), 16'h0100);
      chk(16'({dmem_rd_out, dmem_wr_out}), 16'h0000);
      cyc(3);
      chk(16'({exec_valid_out, instr_out}), 16'h4000 | wd(13'h0100));
      cyc(4);
      chk(16'(instr_out), wd(13'h0101));
   endtask : t_branch
   // Clock out high half of each cycle in RC mode, idle otherwise
   task automatic t_clock_out_pin;
      int hi;
      hi = 0;
      @(posedge sys_clk_in);
      rc_mode_in <= 1'b1;
      cyc(8);
      repeat (8)
      begin
         hi += (clock_out_pin_out === 1'b1);
         cyc(1);
      end
      chk(16'(hi), 16'h0004);
      chk(16'(clock_out_oe_out), 16'h0001);
      @(posedge sys_clk_in);
      rc_mode_in <= 1'b0;
      cyc(4);
      chk(16'({clock_out_oe_out, clock_out_pin_out}), 16'h0000);
   endtask : t_clock_out_pin
   initial
   begin
      t_fetch();
      t_branch();
      t_clock_out_pin();
      results();
   end
endmodule : icp_pipeline_bench
